// [core/cpu_flag_branch_multiply_regs.vh]
/*
  Constants for the flag, branch, call and multiply execution unit:
  operation codes, stack and vector constants.
  Assumes inclusion by bare name from design files under core/.
*/
`ifndef CPU_FLAG_BRANCH_MULTIPLY_REGS_VH
`define CPU_FLAG_BRANCH_MULTIPLY_REGS_VH

// Operation codes presented by instruction decode
`define OP_NOP 5'h00
`define OP_ADD 5'h01
`define OP_ADC 5'h02
`define OP_SUB 5'h03
`define OP_SBB 5'h04
`define OP_CMP 5'h05
`define OP_RR 5'h06
`define OP_RRC 5'h07
`define OP_RL 5'h08
`define OP_RLC 5'h09
`define OP_SWAP 5'h0a
`define OP_MPY 5'h0b
`define OP_JC 5'h0c
`define OP_JNC 5'h0d
`define OP_JZ 5'h0e
`define OP_JNZ 5'h0f
`define OP_JP 5'h10
`define OP_JN 5'h11
`define OP_JPZ 5'h12
`define OP_CALL 5'h13
`define OP_TRAP 5'h14
`define OP_RETURN_FROM_SUBROUTINE 5'h15

// Stack and vector table
`define SP_RESET 8'h01
`define VEC_TOP 16'hffff
`define TRAP_SOFT_MIN 5'h04
`define TRAP_MAX 5'h17

`endif

// [core/rotate_swap_unit.v]
/*
  Combinational rotate and nibble swap unit.
  Assumes the caller supplies the current carry and a rotate selector.
*/
module rotate_swap_unit (
  input wire [4:0] sel_in,
  input wire [7:0] data_in,
  input wire carry_in,
  output reg [7:0] res_out,
  output reg carry_out
);

`include "cpu_flag_branch_multiply_regs.vh"

  // One rotate per selector; unknown selector passes data through
  always @* begin
    res_out = data_in;
    carry_out = carry_in;
    case (sel_in)
      `OP_RR: begin
        res_out = {data_in[0], data_in[7:1]};
        carry_out = data_in[0];
      end
      `OP_RRC: begin // 9-bit loop through carry
        res_out = {carry_in, data_in[7:1]};
        carry_out = data_in[0];
      end
      `OP_RL: begin
        res_out = {data_in[6:0], data_in[7]};
        carry_out = data_in[7];
      end
      `OP_RLC: begin
        res_out = {data_in[6:0], carry_in};
        carry_out = data_in[7];
      end
      `OP_SWAP: begin // Four left rotations
        res_out = {data_in[3:0], data_in[7:4]};
        carry_out = data_in[4];
      end
      default: begin
        res_out = data_in;
        carry_out = carry_in;
      end
    endcase
  end

endmodule

// [core/multiply_unit.v]
/*
  Combinational unsigned 8x8 shift-and-add multiplier.
  Assumes the caller registers the product; the path is one cycle long.
*/
module multiply_unit (
  input wire [7:0] a_in,
  input wire [7:0] b_in,
  output wire [15:0] prod_out
);

  wire [15:0] part [0:7]; // Partial product rows
  wire [15:0] acc [0:8]; // Running sums

  assign acc[0] = 16'h0000;

  // One row per multiplier bit; sum never exceeds 16 bits
  genvar i;
  generate
    for (i = 0; i < 8; i = i + 1) begin : row
      assign part[i] = b_in[i] ? ({8'h00, a_in} << i) : 16'h0000;
      assign acc[i+1] = acc[i] + part[i];
    end
  endgenerate

  assign prod_out = acc[8];

endmodule

// [core/cpu_flag_branch_multiply.v]
/*
  Execution unit for arithmetic flags, conditional jumps, rotates,
  multiply, subroutine call, vectored call and return.
  Assumes decode holds an operation with op_valid_in until op_ready_out,
  a stack RAM and a program memory each answering a read one cycle
  after the read strobe, and the register file taking written results.
*/
module cpu_flag_branch_multiply (
  input wire clk_in,
  input wire rstn_in,
  input wire ce_in,
  input wire op_valid_in,
  input wire [4:0] op_code_in,
  input wire [7:0] dst_in,
  input wire [7:0] src_in,
  input wire [15:0] target_in,
  input wire [15:0] ret_pc_in,
  input wire [4:0] trap_num_in,
  input wire [7:0] stk_rdata_in,
  input wire [7:0] mem_rdata_in,
  output wire op_ready_out,
  output wire done_out,
  output wire [7:0] result_out,
  output wire result_we_out,
  output wire [7:0] upper_product_out,
  output wire [7:0] lower_product_out,
  output wire product_we_out,
  output wire carry_out,
  output wire msb_out,
  output wire equal_out,
  output wire pc_load_out,
  output wire [15:0] pc_next_out,
  output wire branch_taken_out,
  output wire stk_we_out,
  output wire stk_re_out,
  output wire [7:0] stk_addr_out,
  output wire [7:0] stk_wdata_out,
  output wire mem_rd_out,
  output wire [15:0] mem_addr_out,
  output wire [7:0] sp_out
);

`include "cpu_flag_branch_multiply_regs.vh"

  // Sequencer states
  localparam [2:0] S_IDLE = 3'h0; // Ready for the next operation
  localparam [2:0] S_PUSH = 3'h1; // Second push byte
  localparam [2:0] S_VEC1 = 3'h2; // Vector high byte read
  localparam [2:0] S_VEC2 = 3'h3; // Vector low byte read
  localparam [2:0] S_VEC3 = 3'h4; // Vector high byte arrives
  localparam [2:0] S_POP1 = 3'h5; // Second pop read
  localparam [2:0] S_POP2 = 3'h6; // Low byte arrives
  localparam [2:0] S_POP3 = 3'h7; // High byte arrives

  // Control and flag state
  reg [2:0] state_q; // Sequencer state
  reg carry_q; // Borrowless bit
  reg msb_q; // Top bit of last result
  reg equal_q; // Result zero / operands equal / upper product byte zero
  reg [7:0] sp_q; // Stack pointer
  reg is_trap_q; // Call in flight is vectored
  reg [4:0] trap_q; // Vector number in flight
  reg [15:0] ret_q; // Return address being pushed
  reg [15:0] tgt_q; // Call target being built
  reg [7:0] pop_lo_q; // Popped low byte

  // Output registers
  reg done_q;
  reg [7:0] result_q;
  reg result_we_q;
  reg [7:0] upper_q;
  reg [7:0] lower_q;
  reg product_we_q;
  reg pc_load_q;
  reg [15:0] pc_next_q;
  reg taken_q;
  reg stk_we_q;
  reg stk_re_q;
  reg [7:0] stk_addr_q;
  reg [7:0] stk_wdata_q;
  reg mem_rd_q;
  reg [15:0] mem_addr_q;

  // Datapath wires
  wire is_sub; // Subtracting form of the adder
  wire carry_in_w; // Adder carry input
  wire [7:0] operand_b; // Source, inverted for subtraction
  wire [8:0] sum9; // Nine-bit sum, bit 8 is carry / no-borrow
  wire [7:0] rot_res; // Rotate unit result
  wire rot_carry; // Rotate unit carry
  wire [15:0] prod; // Multiplier result
  wire take_op; // Operation accepted this cycle

  // Returns the low-byte address of a vector entry
  function [15:0] vec_lsb;
    input [4:0] num;
    begin
      vec_lsb = `VEC_TOP - {10'h000, num, 1'b0};
    end
  endfunction

  // Jump condition from the three flags; JP tests msb and equal, each other form one flag
  function jump_cond;
    input [4:0] op;
    input c;
    input n;
    input z;
    begin
      case (op)
        `OP_JC: jump_cond = c;
        `OP_JNC: jump_cond = ~c;
        `OP_JZ: jump_cond = z;
        `OP_JNZ: jump_cond = ~z;
        `OP_JP: jump_cond = ~n & ~z;
        `OP_JN: jump_cond = n;
        `OP_JPZ: jump_cond = ~n;
        default: jump_cond = 1'b0;
      endcase
    end
  endfunction

  // One adder serves add, subtract and compare: d + ~s + 1 subtracts
  assign is_sub = (op_code_in == `OP_SUB) || (op_code_in == `OP_SBB) ||
                  (op_code_in == `OP_CMP);
  assign operand_b = is_sub ? ~src_in : src_in;
  // Plain forms fix the carry in; chained forms reuse the flag
  assign carry_in_w = (op_code_in == `OP_ADC) ? carry_q :
                      (op_code_in == `OP_SBB) ? carry_q :
                      is_sub;
  assign sum9 = {1'b0, dst_in} + {1'b0, operand_b} + {8'h00, carry_in_w};

  assign take_op = op_valid_in && (state_q == S_IDLE);

  // Rotates and swap
  rotate_swap_unit i_rotate_swap_unit (
    .sel_in(op_code_in),
    .data_in(dst_in),
    .carry_in(carry_q),
    .res_out(rot_res),
    .carry_out(rot_carry)
  );

  // Multiplier: destination times source
  multiply_unit i_multiply_unit (
    .a_in(dst_in),
    .b_in(src_in),
    .prod_out(prod)
  );

  // Main sequencer, flags and registered outputs; ce_in freezes all but reset
  always @(posedge clk_in) begin
    if (!rstn_in) begin
      state_q <= S_IDLE;
      carry_q <= 1'b0;
      msb_q <= 1'b0;
      equal_q <= 1'b0;
      sp_q <= `SP_RESET;
      is_trap_q <= 1'b0;
      trap_q <= 5'h00;
      ret_q <= 16'h0000;
      tgt_q <= 16'h0000;
      pop_lo_q <= 8'h00;
      done_q <= 1'b0;
      result_q <= 8'h00;
      result_we_q <= 1'b0;
      upper_q <= 8'h00;
      lower_q <= 8'h00;
      product_we_q <= 1'b0;
      pc_load_q <= 1'b0;
      pc_next_q <= 16'h0000;
      taken_q <= 1'b0;
      stk_we_q <= 1'b0;
      stk_re_q <= 1'b0;
      stk_addr_q <= 8'h00;
      stk_wdata_q <= 8'h00;
      mem_rd_q <= 1'b0;
      mem_addr_q <= 16'h0000;
    end else if (ce_in) begin
      // Strobes default low; each lasts one cycle
      done_q <= 1'b0;
      result_we_q <= 1'b0;
      product_we_q <= 1'b0;
      pc_load_q <= 1'b0;
      taken_q <= 1'b0;
      stk_we_q <= 1'b0;
      stk_re_q <= 1'b0;
      mem_rd_q <= 1'b0;
      case (state_q)
        S_IDLE: begin
          if (take_op) begin
            case (op_code_in)
              `OP_ADD, `OP_ADC, `OP_SUB, `OP_SBB: begin
                result_q <= sum9[7:0];
                result_we_q <= 1'b1;
                carry_q <= sum9[8];
                msb_q <= sum9[7];
                equal_q <= (sum9[7:0] == 8'h00);
                done_q <= 1'b1;
              end
              `OP_CMP: begin
                // Flags only; no write strobe
                carry_q <= sum9[8]; // No borrow when d >= s
                msb_q <= sum9[7];
                equal_q <= (dst_in == src_in);
                done_q <= 1'b1;
              end
              `OP_RR, `OP_RRC, `OP_RL, `OP_RLC, `OP_SWAP: begin
                result_q <= rot_res;
                result_we_q <= 1'b1;
                carry_q <= rot_carry;
                msb_q <= rot_res[7];
                equal_q <= (rot_res == 8'h00);
                done_q <= 1'b1;
              end
              `OP_MPY: begin
                upper_q <= prod[15:8];
                lower_q <= prod[7:0];
                product_we_q <= 1'b1;
                // Product cannot overflow, so carry is cleared
                carry_q <= 1'b0;
                msb_q <= prod[15];
                equal_q <= (prod[15:8] == 8'h00);
                done_q <= 1'b1;
              end
              `OP_JC, `OP_JNC, `OP_JZ, `OP_JNZ,
              `OP_JP, `OP_JN, `OP_JPZ: begin
                // Flags are read, never written, by a jump
                taken_q <= jump_cond(op_code_in, carry_q, msb_q, equal_q);
                pc_load_q <= jump_cond(op_code_in, carry_q, msb_q,
                                       equal_q);
                pc_next_q <= target_in;
                done_q <= 1'b1;
              end
              `OP_CALL, `OP_TRAP: begin
                if ((op_code_in == `OP_TRAP) &&
                    (trap_num_in > `TRAP_MAX)) begin
                  // No vector beyond the table: ignored
                  done_q <= 1'b1;
                end else begin
                  // First push: return high byte
                  ret_q <= ret_pc_in;
                  tgt_q <= target_in;
                  is_trap_q <= (op_code_in == `OP_TRAP);
                  trap_q <= trap_num_in;
                  sp_q <= sp_q + 8'h01;
                  stk_we_q <= 1'b1;
                  stk_addr_q <= sp_q + 8'h01;
                  stk_wdata_q <= ret_pc_in[15:8];
                  state_q <= S_PUSH;
                end
              end
              `OP_RETURN_FROM_SUBROUTINE: begin
                // Low byte sits on top
                stk_re_q <= 1'b1;
                stk_addr_q <= sp_q;
                sp_q <= sp_q - 8'h01;
                state_q <= S_POP1;
              end
              default: begin
                // Unknown or no-op code completes with no effect
                done_q <= 1'b1;
              end
            endcase
          end
        end
        S_PUSH: begin
          // Second push: return low byte
          sp_q <= sp_q + 8'h01;
          stk_we_q <= 1'b1;
          stk_addr_q <= sp_q + 8'h01;
          stk_wdata_q <= ret_q[7:0];
          if (is_trap_q) begin
            state_q <= S_VEC1;
          end else begin
            // Direct call jumps once both bytes are queued
            pc_load_q <= 1'b1;
            taken_q <= 1'b1;
            pc_next_q <= tgt_q;
            done_q <= 1'b1;
            state_q <= S_IDLE;
          end
        end
        S_VEC1: begin
          // High byte at the lower address
          mem_rd_q <= 1'b1;
          mem_addr_q <= vec_lsb(trap_q) - 16'h0001;
          state_q <= S_VEC2;
        end
        S_VEC2: begin
          // Low byte address
          mem_rd_q <= 1'b1;
          mem_addr_q <= vec_lsb(trap_q);
          state_q <= S_VEC3;
        end
        S_VEC3: begin
          // High byte answered for the first read
          tgt_q[15:8] <= mem_rdata_in;
          state_q <= S_POP3;
          is_trap_q <= 1'b1;
        end
        S_POP1: begin
          // High byte is one below
          stk_re_q <= 1'b1;
          stk_addr_q <= sp_q;
          sp_q <= sp_q - 8'h01;
          is_trap_q <= 1'b0;
          state_q <= S_POP2;
        end
        S_POP2: begin
          pop_lo_q <= stk_rdata_in;
          state_q <= S_POP3;
        end
        S_POP3: begin
          // Shared finish: vector low byte or popped high byte
          pc_load_q <= 1'b1;
          taken_q <= 1'b1;
          if (is_trap_q) begin
            pc_next_q <= {tgt_q[15:8], mem_rdata_in};
          end else begin
            pc_next_q <= {stk_rdata_in, pop_lo_q};
          end
          is_trap_q <= 1'b0;
          done_q <= 1'b1;
          state_q <= S_IDLE;
        end
        default: begin
          state_q <= S_IDLE;
        end
      endcase
    end
  end

  // Ready is combinational so decode can issue back to back
  assign op_ready_out = (state_q == S_IDLE);
  assign done_out = done_q;
  assign result_out = result_q;
  assign result_we_out = result_we_q;
  assign upper_product_out = upper_q;
  assign lower_product_out = lower_q;
  assign product_we_out = product_we_q;
  assign carry_out = carry_q;
  assign msb_out = msb_q;
  assign equal_out = equal_q;
  assign pc_load_out = pc_load_q;
  assign pc_next_out = pc_next_q;
  assign branch_taken_out = taken_q;
  assign stk_we_out = stk_we_q;
  assign stk_re_out = stk_re_q;
  assign stk_addr_out = stk_addr_q;
  assign stk_wdata_out = stk_wdata_q;
  assign mem_rd_out = mem_rd_q;
  assign mem_addr_out = mem_addr_q;
  assign sp_out = sp_q;

endmodule

// [tb/cpu_flag_branch_multiply_assertions.sv]
/*
  Port checker for the flag, branch, call and multiply unit.
  Assumes a bind from the bench, one clock and a synchronous reset.
*/
`include "cpu_flag_branch_multiply_regs.vh"
module cpu_flag_branch_multiply_assertions (
  input logic clk_in,
  input logic rstn_in,
  input logic ce_in,
  input logic op_valid_in,
  input logic [4:0] op_code_in,
  input logic [7:0] dst_in,
  input logic [7:0] src_in,
  input logic op_ready_out,
  input logic [7:0] result_out,
  input logic result_we_out,
  input logic [7:0] upper_product_out,
  input logic [7:0] lower_product_out,
  input logic carry_out,
  input logic msb_out,
  input logic equal_out,
  input logic pc_load_out,
  input logic branch_taken_out,
  input logic stk_we_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] diff_q; // Difference seen at the take edge
  wire tk = rstn_in && ce_in && op_valid_in && op_ready_out; // Op taken
  // Kept so the msb check compares against the full subtraction
  always @(posedge clk_in) begin
    diff_q <= dst_in - src_in;
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);
  property p_cmp_carry;
    tk && op_code_in == `OP_CMP |=>
      carry_out == ($past(dst_in) >= $past(src_in));
  endproperty
  a_cmp_carry: assert property (p_cmp_carry)
    else $error("compare carry wrong");
  property p_cmp_msb;
    tk && op_code_in == `OP_CMP |=> msb_out == diff_q[7];
  endproperty
  a_cmp_msb: assert property (p_cmp_msb)
    else $error("compare msb wrong");
  property p_cmp_eq;
    tk && op_code_in == `OP_CMP |=>
      equal_out == ($past(dst_in) == $past(src_in));
  endproperty
  a_cmp_eq: assert property (p_cmp_eq)
    else $error("compare equal wrong");
  property p_cmp_keep;
    tk && op_code_in == `OP_CMP |=> !result_we_out && $stable(result_out);
  endproperty
  a_cmp_keep: assert property (p_cmp_keep)
    else $error("compare wrote a result");
  property p_jmp_carry;
    tk && op_code_in == `OP_JC |=> branch_taken_out == $past(carry_out);
  endproperty
  a_jmp_carry: assert property (p_jmp_carry)
    else $error("carry jump wrong");
  property p_jmp_zero;
    tk && op_code_in == `OP_JZ |=> pc_load_out == $past(equal_out);
  endproperty
  a_jmp_zero: assert property (p_jmp_zero)
    else $error("zero jump wrong");
  property p_jmp_neg;
    tk && op_code_in == `OP_JN |=> branch_taken_out == $past(msb_out);
  endproperty
  a_jmp_neg: assert property (p_jmp_neg)
    else $error("negative jump wrong");
  property p_add_carry;
    tk && op_code_in == `OP_ADC |=> result_out ==
      8'($past(dst_in) + $past(src_in) + {7'h00, $past(carry_out)});
  endproperty
  a_add_carry: assert property (p_add_carry)
    else $error("add with carry wrong");
  property p_mul;
    tk && op_code_in == `OP_MPY |=> {upper_product_out, lower_product_out}
      == {8'h00, $past(dst_in)} * {8'h00, $past(src_in)};
  endproperty
  a_mul: assert property (p_mul)
    else $error("product wrong");
  property p_call_push;
    tk && op_code_in == `OP_CALL |=> stk_we_out ##1 stk_we_out && pc_load_out;
  endproperty
  a_call_push: assert property (p_call_push)
    else $error("call push wrong");
endmodule

// [tb/cpu_flag_branch_multiply_test.sv]
/*
  Self-checking bench for the flag, branch, call and multiply unit.
  Assumes the core/ files and the checker are compiled before it.
*/
`include "cpu_flag_branch_multiply_regs.vh"
module cpu_flag_branch_multiply_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_in = 1'b0;
  logic rstn_in = 1'b0; // Held low at start
  logic ce_in = 1'b1; // Dropped only by the hold scenario
  logic op_valid_in = 1'b0;
  logic [4:0] op_code_in = 5'h00;
  logic [7:0] dst_in = 8'h00;
  logic [7:0] src_in = 8'h00;
  logic [15:0] target_in = 16'h0000;
  logic [15:0] ret_pc_in = 16'h0000;
  logic [4:0] trap_num_in = 5'h00;
  logic [7:0] stk_rdata_in = 8'h00;
  logic [7:0] mem_rdata_in = 8'h00;
  wire op_ready_out, done_out, result_we_out, product_we_out;
  wire carry_out, msb_out, equal_out, pc_load_out, branch_taken_out;
  wire stk_we_out, stk_re_out, mem_rd_out;
  wire [7:0] result_out, upper_product_out, lower_product_out;
  wire [7:0] stk_addr_out, stk_wdata_out, sp_out;
  wire [15:0] pc_next_out, mem_addr_out;
  logic [7:0] stk_mem [0:255]; // Stack RAM stand-in
  logic got_load, got_taken; // Captured at done
  logic [15:0] got_pc;
  int err_count = 0;
  int n_checks = 0;
  int cyc = 0;
  cpu_flag_branch_multiply i_cpu_flag_branch_multiply (
    .clk_in(clk_in), .rstn_in(rstn_in), .ce_in(ce_in),
    .op_valid_in(op_valid_in), .op_code_in(op_code_in),
    .dst_in(dst_in), .src_in(src_in), .target_in(target_in),
    .ret_pc_in(ret_pc_in), .trap_num_in(trap_num_in),
    .stk_rdata_in(stk_rdata_in), .mem_rdata_in(mem_rdata_in),
    .op_ready_out(op_ready_out), .done_out(done_out),
    .result_out(result_out), .result_we_out(result_we_out),
    .upper_product_out(upper_product_out),
    .lower_product_out(lower_product_out),
    .product_we_out(product_we_out), .carry_out(carry_out),
    .msb_out(msb_out), .equal_out(equal_out), .pc_load_out(pc_load_out),
    .pc_next_out(pc_next_out), .branch_taken_out(branch_taken_out),
    .stk_we_out(stk_we_out), .stk_re_out(stk_re_out),
    .stk_addr_out(stk_addr_out), .stk_wdata_out(stk_wdata_out),
    .mem_rd_out(mem_rd_out), .mem_addr_out(mem_addr_out), .sp_out(sp_out)
  );
  // Clock, 8 ns period
  always #4 clk_in = ~clk_in;
  // Vector table contents, derived from the address
  function automatic logic [7:0] vec_byte(input logic [15:0] a);
    return a[7:0] ^ 8'h3c;
  endfunction
  // Stack and program memory answer in the cycle after a strobe
  always @(posedge clk_in) begin
    if (stk_we_out) stk_mem[stk_addr_out] <= stk_wdata_out;
    if (stk_re_out) stk_rdata_in <= stk_mem[stk_addr_out];
    if (mem_rd_out) mem_rdata_in <= vec_byte(mem_addr_out);
  end
  // Hang guard, well above the expected run length
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      err_count++;
      complete_run();
    end
  end
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic check_val(input string what, input logic [15:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One operation: offer, take, then wait a bounded time for done
  task automatic run_op(input logic [4:0] op, input logic [7:0] d, s);
    int i;
    @(negedge clk_in);
    op_valid_in = 1'b1;
    op_code_in = op;
    dst_in = d;
    src_in = s;
    @(negedge clk_in);
    op_valid_in = 1'b0;
    for (i = 0; i < 10 && done_out !== 1'b1; i++) @(negedge clk_in);
    check_val("done", done_out, 1'b1);
    got_load = pc_load_out;
    got_taken = branch_taken_out;
    got_pc = pc_next_out;
  endtask
  // Compare chosen so the carry comes out as asked
  task automatic set_carry(input logic c);
    run_op(`OP_CMP, c ? 8'hff : 8'h00, 8'h01);
  endtask
  task automatic t_compare;
    logic [15:0] pr [8] = '{16'h00ff, 16'h007f, 16'h8100, 16'h8000,
      16'h7f80, 16'h807f, 16'h7f7f, 16'h7f00}; // {source, destination}
    logic [2:0] fl [8] = '{3'b110, 3'b100, 3'b000, 3'b010,
      3'b100, 3'b010, 3'b101, 3'b010}; // {carry, msb, equal}
    logic [7:0] keep;
    logic t;
    for (int r = 0; r < 8; r++) begin
      keep = result_out;
      run_op(`OP_CMP, pr[r][7:0], pr[r][15:8]);
      check_val("carry", carry_out, fl[r][2]);
      check_val("msb", msb_out, fl[r][1]);
      check_val("equal", equal_out, fl[r][0]);
      check_val("result kept", result_out, keep);
      for (int j = 0; j < 7; j++) begin
        target_in = {8'hc0, r[3:0], j[3:0]};
        case (j)
          0: t = fl[r][2];
          1: t = !fl[r][2];
          2: t = fl[r][0];
          3: t = !fl[r][0];
          4: t = !fl[r][1] && !fl[r][0];
          5: t = fl[r][1];
          default: t = !fl[r][1];
        endcase
        run_op(`OP_JC + j[4:0], 8'h00, 8'h00);
        check_val("taken", got_taken, t);
        check_val("load", got_load, t);
        if (t) check_val("jump pc", got_pc, target_in);
      end
    end
  endtask
  task automatic t_chain;
    logic [31:0] a, b, s;
    a = 32'h12ff_ff80;
    b = 32'h0000_0090;
    s = a + b;
    set_carry(1'b1);
    for (int i = 0; i < 4; i++) begin
      run_op(i == 0 ? `OP_ADD : `OP_ADC, a[8*i+:8], b[8*i+:8]);
      check_val("sum byte", result_out, s[8*i+:8]);
    end
    a = 32'h0010_0005;
    b = 32'h0000_0007;
    s = a - b;
    set_carry(1'b0);
    for (int i = 0; i < 3; i++) begin
      run_op(i == 0 ? `OP_SUB : `OP_SBB, a[8*i+:8], b[8*i+:8]);
      check_val("diff byte", result_out, s[8*i+:8]);
    end
    check_val("no borrow", carry_out, 1'b1);
  endtask
  task automatic t_rot;
    logic [7:0] d, e;
    logic cx;
    d = 8'h96;
    for (int c = 0; c < 2; c++) begin
      for (int k = 0; k < 5; k++) begin
        set_carry(c[0]);
        case (k)
          0: {e, cx} = {d[0], d[7:1], d[0]};
          1: {e, cx} = {c[0], d[7:1], d[0]};
          2: {e, cx} = {d[6:0], d[7], d[7]};
          3: {e, cx} = {d[6:0], c[0], d[7]};
          default: {e, cx} = {d[3:0], d[7:4], d[4]};
        endcase
        run_op(`OP_RR + k[4:0], d, d);
        check_val("rotated", result_out, e);
        check_val("rot carry", carry_out, cx);
      end
    end
  endtask
  task automatic t_mul;
    logic [7:0] hi, lo;
    for (int k = 1; k < 8; k++) begin
      hi = 8'hb5 >> (8 - k);
      lo = 8'hb5 << k;
      run_op(`OP_MPY, 8'hb5, 8'h01 << k);
      check_val("upper", upper_product_out, hi);
      check_val("lower", lower_product_out, lo);
    end
    run_op(`OP_MPY, 8'hff, 8'hff);
    check_val("product", {upper_product_out, lower_product_out},
      16'hfe01);
    check_val("prod we", product_we_out, 1'b1);
  endtask
  // Clock enable low: an offered add must leave everything frozen
  task automatic t_hold;
    logic [7:0] r;
    r = result_out;
    @(negedge clk_in);
    ce_in = 1'b0;
    op_valid_in = 1'b1;
    op_code_in = `OP_ADD;
    dst_in = 8'h11;
    src_in = 8'h22;
    repeat (3) @(negedge clk_in);
    check_val("frozen", {done_out, result_out}, {1'b0, r});
    check_val("frozen sp", sp_out, 8'h01);
    op_valid_in = 1'b0;
    ce_in = 1'b1;
  endtask
  // Nested call and vectored calls, refused number, then unwinding
  task automatic t_sub;
    ret_pc_in = 16'h1234;
    target_in = 16'h4567;
    run_op(`OP_CALL, 8'h00, 8'h00);
    check_val("call pc", got_pc, 16'h4567);
    // Low byte lands in the stack RAM one edge after done
    @(negedge clk_in);
    check_val("push", {stk_mem[2], stk_mem[3]}, 16'h1234);
    for (int n = 4; n < 24; n += 19) begin
      trap_num_in = n[4:0];
      ret_pc_in = {8'h45, n[7:0]};
      run_op(`OP_TRAP, 8'h00, 8'h00);
      check_val("vec pc", got_pc, {vec_byte(16'hfffe - 2 * n),
        vec_byte(16'hffff - 2 * n)});
    end
    trap_num_in = 5'h18;
    run_op(`OP_TRAP, 8'h00, 8'h00);
    check_val("refused", {got_load, sp_out}, 16'h0007);
    for (int n = 23; n > -1; n -= 19) begin
      run_op(`OP_RETURN_FROM_SUBROUTINE, 8'h00, 8'h00);
      check_val("return", got_pc, {8'h45, n[7:0]});
    end
    run_op(`OP_RETURN_FROM_SUBROUTINE, 8'h00, 8'h00);
    check_val("return", got_pc, 16'h1234);
    check_val("sp", sp_out, 8'h01);
  endtask
  initial begin
    repeat (6) @(posedge clk_in);
    @(negedge clk_in);
    rstn_in = 1'b1;
    check_val("sp reset", sp_out, 8'h01);
    check_val("ready", op_ready_out, 1'b1);
    t_compare();
    t_chain();
    t_rot();
    t_mul();
    t_sub();
    t_hold();
    complete_run();
  end
endmodule
bind cpu_flag_branch_multiply cpu_flag_branch_multiply_assertions
  i_cpu_flag_branch_multiply_assertions (
  .clk_in(clk_in), .rstn_in(rstn_in), .ce_in(ce_in),
  .op_valid_in(op_valid_in), .op_code_in(op_code_in), .dst_in(dst_in),
  .src_in(src_in), .op_ready_out(op_ready_out), .result_out(result_out),
  .result_we_out(result_we_out), .upper_product_out(upper_product_out),
  .lower_product_out(lower_product_out), .carry_out(carry_out),
  .msb_out(msb_out), .equal_out(equal_out), .pc_load_out(pc_load_out),
  .branch_taken_out(branch_taken_out), .stk_we_out(stk_we_out)
);
